// ==== design/sscsb_pkg.sv ====
// Package: item codes, bit positions, reset values and carriers of the control/status bank
package sscsb_pkg;
  localparam int WORD_W = 16;
  localparam int ADDON_N = 3;

  // Item selector of the register port
  typedef enum logic [2:0] {
    ITEM_ALARM_CFG = 3'h0,
    ITEM_FRONT_IN = 3'h1,
    ITEM_FRONT_OUT = 3'h2,
    ITEM_RESET_CFG = 3'h3,
    ITEM_HEALTH = 3'h4
  } sscsb_item_t;

  // Alarm config field layout
  localparam int ALM_EN = 0;
  localparam int ALM_ALWAYS = 1;
  localparam int ALM_COND_LSB = 2;
  localparam int ALM_FN_W = 6;
  localparam int ALM_MASK_LSB = 8;
  localparam logic [ALM_FN_W-1:0] ALM_FN_RST = 6'h00;

  // Reset config layout
  localparam int RCF_BP_CPU = 0;
  localparam int RCF_BP_FRONT = 2;
  localparam int RCF_CPU_FRONT = 3;
  localparam logic [WORD_W-1:0] RCF_RST = 16'h0032;

  // Two-bit signed health codes
  localparam logic [1:0] HLT_FAIL = 2'h3;
  localparam logic [1:0] HLT_ABSENT = 2'h0;
  localparam logic [1:0] HLT_GOOD = 2'h1;

  // Asynchronous front panel and supply lines
  typedef struct packed {
    logic vsel;
    logic isel;
    logic kill;
    logic interlock;
    logic remote_en;
    logic local_en;
    logic nim_sel;
    logic overcurrent_flag;
    logic undervoltage_flag;
    logic overvoltage_flag;
    logic channel_on_flag;
    logic fan_fail;
    logic overtemperature_flag;
    logic overvoltage_cond;
    logic overcurrent_cond;
    logic undervoltage_cond;
    logic trip_cond;
    logic cpu_fail;
    logic front_reset;
    logic mains_good;
    logic primary_good;
    logic [ADDON_N-1:0] addon_present;
    logic [ADDON_N-1:0] addon_good;
  } sscsb_pins_t;

  // Health report, one code per source
  typedef struct packed {
    logic [ADDON_N-1:0][1:0] addon;
    logic [1:0] primary;
    logic [1:0] mains_input_health;
  } sscsb_health_t;
endpackage

// ==== design/sscsb_top.sv ====
// Control and status bank: alarm output config, front panel snapshots, reset routing, health
`timescale 1ns/1ps
module sscsb_top
  import sscsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire sscsb_pins_t pins,
  input wire sscsb_item_t item,
  input wire logic wr_en,
  input wire logic [WORD_W-1:0] wr_data,
  input wire logic rd_en,
  output logic [WORD_W-1:0] rd_data,
  output logic rd_valid,
  output logic alarm_output,
  output logic backplane_reset,
  output logic cpu_reset,
  output sscsb_health_t supply_module_health
);
  // Masked merge: function bit changes only where its mask is set
  function automatic logic [ALM_FN_W-1:0] masked_merge(input logic [ALM_FN_W-1:0] old_fn,
                                                      input logic [WORD_W-1:0] data);
    logic [ALM_FN_W-1:0] mask;
    mask = data[ALM_MASK_LSB +: ALM_FN_W];
    masked_merge = (old_fn & ~mask) | (data[ALM_FN_W-1:0] & mask);
  endfunction

  // Health code from presence and good lines
  function automatic logic [1:0] health_code(input logic present, input logic good);
    health_code = !present ? HLT_ABSENT : (good ? HLT_GOOD : HLT_FAIL);
  endfunction

  sscsb_pins_t meta_q;
  sscsb_pins_t sync_q;
  logic [ALM_FN_W-1:0] alarm_fn_q;
  logic [ALM_FN_W-1:0] alarm_fn_d;
  logic [WORD_W-1:0] reset_cfg_q;
  logic [WORD_W-1:0] rd_data_q;
  logic rd_valid_q;
  logic alarm_q;
  logic bp_reset_q;
  logic cpu_reset_q;
  sscsb_health_t health_q;
  sscsb_health_t health_d;

  // Pins are asynchronous; two flops before any logic looks at them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // Write decode
  wire wr_alarm = wr_en && (item == ITEM_ALARM_CFG);
  wire wr_reset = wr_en && (item == ITEM_RESET_CFG);
  // Bits 6..7 and 14..15 never reach storage; masks are consumed, not kept
  assign alarm_fn_d = wr_alarm ? masked_merge(alarm_fn_q, wr_data) : alarm_fn_q;

  // Configuration storage
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_fn_q <= ALM_FN_RST;
      reset_cfg_q <= RCF_RST;
    end else begin
      alarm_fn_q <= alarm_fn_d;
      if (wr_reset) begin
        reset_cfg_q <= wr_data; // Stored as written; writers keep fixed bits
      end
    end
  end

  // Snapshot words built from the synchronised lines; the alarm word comes from the stored functions
  wire [WORD_W-1:0] front_in_word = {9'h000, sync_q.nim_sel, sync_q.local_en,
    sync_q.remote_en, sync_q.interlock, sync_q.kill, sync_q.isel, sync_q.vsel};
  wire [WORD_W-1:0] front_out_word = {6'h00, sync_q.overtemperature_flag, sync_q.fan_fail,
    4'h0, sync_q.channel_on_flag, sync_q.overvoltage_flag, sync_q.undervoltage_flag,
    sync_q.overcurrent_flag};
  wire [WORD_W-1:0] alarm_word = {{(WORD_W-ALM_FN_W){1'b0}}, alarm_fn_q};
  wire [WORD_W-1:0] health_word = {{(WORD_W-$bits(sscsb_health_t)){1'b0}}, health_q};

  // Read selection; an unknown item reads zero
  wire [WORD_W-1:0] rd_mux =
    (item == ITEM_ALARM_CFG) ? alarm_word :
    (item == ITEM_FRONT_IN) ? front_in_word :
    (item == ITEM_FRONT_OUT) ? front_out_word :
    (item == ITEM_RESET_CFG) ? reset_cfg_q :
    (item == ITEM_HEALTH) ? health_word : 16'h0000;

  // Read answer one cycle after the strobe; data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
      if (rd_en) begin
        rd_data_q <= rd_mux;
      end
    end
  end

  // Alarm condition: enable gates both the force bit and the selected conditions
  wire [3:0] cond_vec = {sync_q.trip_cond, sync_q.undervoltage_cond,
    sync_q.overcurrent_cond, sync_q.overvoltage_cond};
  wire cond_hit = |(alarm_fn_q[ALM_COND_LSB +: 4] & cond_vec);
  wire alarm_d = alarm_fn_q[ALM_EN] && (alarm_fn_q[ALM_ALWAYS] || cond_hit);

  // Reset routing
  wire bp_reset_d = (reset_cfg_q[RCF_BP_CPU] && sync_q.cpu_fail) ||
    (reset_cfg_q[RCF_BP_FRONT] && sync_q.front_reset);
  wire cpu_reset_d = reset_cfg_q[RCF_CPU_FRONT] && sync_q.front_reset;

  // Health codes; main and primary are always present
  always_comb begin
    health_d.mains_input_health = health_code(1'b1, sync_q.mains_good);
    health_d.primary = health_code(1'b1, sync_q.primary_good);
    for (int i = 0; i < ADDON_N; i++) begin
      health_d.addon[i] = health_code(sync_q.addon_present[i], sync_q.addon_good[i]);
    end
  end

  // Registered outputs so no pin sees a combinational glitch
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      alarm_q <= 1'b0;
      bp_reset_q <= 1'b0;
      cpu_reset_q <= 1'b0;
      health_q <= '0;
    end else begin
      alarm_q <= alarm_d;
      bp_reset_q <= bp_reset_d;
      cpu_reset_q <= cpu_reset_d;
      health_q <= health_d;
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign alarm_output = alarm_q;
  assign backplane_reset = bp_reset_q;
  assign cpu_reset = cpu_reset_q;
  assign supply_module_health = health_q;

  // Checks next to the logic they guard
  AST_ALARM_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_alarm |=> alarm_fn_q == (($past(alarm_fn_q) & ~$past(wr_data[13:8])) |
                                ($past(wr_data[5:0]) & $past(wr_data[13:8]))))
    else $error("alarm config masked write wrong");
  AST_MASK_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_alarm && wr_data[13:8] == 6'h00) |=> $stable(alarm_fn_q))
    else $error("alarm config changed without mask");
  AST_ALARM_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en && item == ITEM_ALARM_CFG) |=> rd_data[15:6] == 10'h000)
    else $error("alarm config unused bits not zero");
  AST_FRONT_IN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en && item == ITEM_FRONT_IN) |=> rd_data[15:7] == 9'h000 &&
      rd_data[0] == $past(sync_q.vsel) && rd_data[6] == $past(sync_q.nim_sel) &&
      rd_data[2] == $past(sync_q.kill))
    else $error("front input word wrong");
  AST_FRONT_OUT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (rd_en && item == ITEM_FRONT_OUT) |=> rd_data[15:10] == 6'h00 && rd_data[7:4] == 4'h0 &&
      rd_data[8] == $past(sync_q.fan_fail) && rd_data[3] == $past(sync_q.channel_on_flag))
    else $error("front output word wrong");
  AST_ALARM_OFF: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !alarm_fn_q[ALM_EN] |=> !alarm_output)
    else $error("alarm active while disabled");
  AST_ALARM_ON: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (alarm_fn_q[ALM_EN] && (alarm_fn_q[ALM_ALWAYS] || (alarm_fn_q[2] && sync_q.overvoltage_cond)
      || (alarm_fn_q[5] && sync_q.trip_cond))) |=> alarm_output)
    else $error("alarm not active when due");
  AST_BP_RESET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reset_cfg_q[0] && sync_q.cpu_fail) |=> backplane_reset)
    else $error("backplane reset missing on processor failure");
  AST_CPU_RESET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    cpu_reset |-> $past(reset_cfg_q[3] && sync_q.front_reset))
    else $error("processor reset without cause");
  AST_HEALTH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !sync_q.addon_present[0] |=> supply_module_health.addon[0] == 2'h0)
    else $error("absent add-on not coded zero");

  // Read port: one answer pulse per strobe, data held between reads
  AST_RD_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd_en |=> rd_valid)
    else $error("read strobe not answered");
  AST_RD_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !rd_en |=> !rd_valid && $stable(rd_data))
    else $error("read answer without strobe");

  // Stored configuration only moves on its own write
  AST_FN_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !wr_alarm |=> $stable(alarm_fn_q))
    else $error("alarm config changed without write");
  AST_RCF_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_reset |=> reset_cfg_q == $past(wr_data))
    else $error("reset config write lost");

  // Alarm: the two middle conditions fire it, and nothing fires it when no cause stands
  AST_ALARM_MID: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (alarm_fn_q[ALM_EN] && ((alarm_fn_q[ALM_COND_LSB+1] && sync_q.overcurrent_cond) ||
      (alarm_fn_q[ALM_COND_LSB+2] && sync_q.undervoltage_cond))) |=> alarm_output)
    else $error("alarm missed a selected condition");
  AST_ALARM_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!alarm_fn_q[ALM_ALWAYS] && !(alarm_fn_q[ALM_COND_LSB] && sync_q.overvoltage_cond) &&
      !(alarm_fn_q[ALM_COND_LSB+1] && sync_q.overcurrent_cond) &&
      !(alarm_fn_q[ALM_COND_LSB+2] && sync_q.undervoltage_cond) &&
      !(alarm_fn_q[ALM_COND_LSB+3] && sync_q.trip_cond)) |=> !alarm_output)
    else $error("alarm active with no selected condition");

  // Reset routing: the front reset reaches each enabled target, and the backplane reset has no other cause
  AST_BP_FRONT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reset_cfg_q[RCF_BP_FRONT] && sync_q.front_reset) |=> backplane_reset)
    else $error("backplane reset missing on front reset");
  AST_CPU_FRONT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (reset_cfg_q[RCF_CPU_FRONT] && sync_q.front_reset) |=> cpu_reset)
    else $error("processor reset missing on front reset");
  AST_BP_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!(reset_cfg_q[RCF_BP_CPU] && sync_q.cpu_fail) &&
      !(reset_cfg_q[RCF_BP_FRONT] && sync_q.front_reset)) |=> !backplane_reset)
    else $error("backplane reset without enabled cause");

  // Health codes in two-bit form: -1 reads 2'h3, +1 reads 2'h1
  AST_HEALTH_FIXED: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> (supply_module_health.mains_input_health ==
      ($past(sync_q.mains_good) ? 2'h1 : 2'h3)) && (supply_module_health.primary ==
      ($past(sync_q.primary_good) ? 2'h1 : 2'h3)))
    else $error("mains or primary health code wrong");
  AST_HEALTH_FAIL: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sync_q.addon_present[1] && !sync_q.addon_good[1]) |=> supply_module_health.addon[1] == 2'h3)
    else $error("failed add-on not coded minus one");
  AST_HEALTH_GOOD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sync_q.addon_present[0] && sync_q.addon_good[0]) |=> supply_module_health.addon[0] == 2'h1)
    else $error("good add-on not coded one");
endmodule // sscsb_top

// ==== dv/sscsb_panel_model.sv ====
// Front panel and supply line model driving the bank's pin inputs
`timescale 1ns/1ps
module sscsb_panel_model
  import sscsb_pkg::*;
(
  input wire logic ref_clk,
  input wire sscsb_pins_t want,
  output sscsb_pins_t pins
);
  // Lines move at the falling edge, so no sample lands on a moving level
  initial pins = '0;
  always @(negedge ref_clk) pins <= want;
endmodule // sscsb_panel_model

// ==== dv/sscsb_top_tb.sv ====
// Self-checking bench of the control and status bank
`timescale 1ns/1ps
module sscsb_top_tb
  import sscsb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  sscsb_pins_t want = '0;
  sscsb_pins_t pins;
  sscsb_item_t item = ITEM_ALARM_CFG;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [WORD_W-1:0] wr_data = 16'h0000;
  logic [WORD_W-1:0] rd_data;
  logic rd_valid;
  logic alarm_output;
  logic backplane_reset;
  logic cpu_reset;
  sscsb_health_t supply_module_health;
  int failures = 0;
  int n_tests = 0;

  always #2.5 ref_clk = ~ref_clk;

  sscsb_panel_model u_sscsb_panel_model (.ref_clk(ref_clk), .want(want), .pins(pins));
  sscsb_top u_sscsb_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .pins(pins), .item(item),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
    .alarm_output(alarm_output), .backplane_reset(backplane_reset), .cpu_reset(cpu_reset),
    .supply_module_health(supply_module_health));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobes rise and fall at falling edges, one rising edge in between
  task automatic wr(input sscsb_item_t it, input logic [15:0] d);
    @(negedge ref_clk);
    item = it;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge ref_clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input sscsb_item_t it, input logic [15:0] exp, input string nm);
    @(negedge ref_clk);
    item = it;
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk(nm, exp, rd_data);
  endtask

  // Pins need two sync flops plus the output register before they show
  task automatic settle();
    repeat (4) @(negedge ref_clk);
  endtask

  task automatic setc(input logic [3:0] c);
    want.overvoltage_cond = c[0];
    want.overcurrent_cond = c[1];
    want.undervoltage_cond = c[2];
    want.trip_cond = c[3];
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs about 135 cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    test_done();
  end

  initial begin
    logic [6:0] fi;
    logic [5:0] fo;
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(ITEM_ALARM_CFG, 16'h0000, "alarm cfg reset");
    rd(ITEM_RESET_CFG, 16'h0032, "reset cfg reset");
    wr(ITEM_ALARM_CFG, 16'h003F);
    rd(ITEM_ALARM_CFG, 16'h0000, "unmasked write");
    wr(ITEM_ALARM_CFG, 16'hC1C1);
    rd(ITEM_ALARM_CFG, 16'h0001, "enable only");
    wr(ITEM_ALARM_CFG, 16'h3E3E);
    rd(ITEM_ALARM_CFG, 16'h003F, "all functions");
    settle();
    chk("forced alarm", 16'h0001, {15'h0000, alarm_output});
    wr(ITEM_ALARM_CFG, 16'h0200);
    rd(ITEM_ALARM_CFG, 16'h003D, "clear forced");
    $display("test mask_write done");
    // One condition selected at a time; the others present must not fire it
    for (int i = 0; i < 4; i++) begin
      wr(ITEM_ALARM_CFG, 16'h3E00 | (16'h0004 << i));
      setc(~(4'h1 << i));
      settle();
      chk("alarm other cond", 16'h0000, {15'h0000, alarm_output});
      setc(4'hF);
      settle();
      chk("alarm own cond", 16'h0001, {15'h0000, alarm_output});
    end
    wr(ITEM_ALARM_CFG, 16'h0100);
    settle();
    chk("alarm disabled", 16'h0000, {15'h0000, alarm_output});
    setc(4'h0);
    $display("test alarm done");
    for (int p = 0; p < 2; p++) begin
      fi = (p == 0) ? 7'h55 : 7'h2A;
      fo = (p == 0) ? 6'h15 : 6'h2A;
      {want.nim_sel, want.local_en, want.remote_en, want.interlock} = fi[6:3];
      {want.kill, want.isel, want.vsel} = fi[2:0];
      {want.overtemperature_flag, want.fan_fail, want.channel_on_flag} = fo[5:3];
      {want.overvoltage_flag, want.undervoltage_flag, want.overcurrent_flag} = fo[2:0];
      settle();
      rd(ITEM_FRONT_IN, {9'h000, fi}, "front in");
      rd(ITEM_FRONT_OUT, {6'h00, fo[5:4], 4'h0, fo[3:0]}, "front out");
    end
    wr(ITEM_FRONT_IN, 16'hFFFF);
    rd(ITEM_FRONT_IN, 16'h002A, "front in after write");
    $display("test front_panel done");
    wr(ITEM_RESET_CFG, 16'h0033);
    want.cpu_fail = 1'b1;
    settle();
    chk("bp from cpu fail", 16'h0001, {15'h0000, backplane_reset});
    want.cpu_fail = 1'b0;
    want.front_reset = 1'b1;
    wr(ITEM_RESET_CFG, 16'h003E);
    rd(ITEM_RESET_CFG, 16'h003E, "reset cfg");
    settle();
    chk("bp from front", 16'h0001, {15'h0000, backplane_reset});
    chk("cpu from front", 16'h0001, {15'h0000, cpu_reset});
    wr(ITEM_RESET_CFG, 16'h0032);
    settle();
    chk("bp routing off", 16'h0000, {15'h0000, backplane_reset});
    chk("cpu routing off", 16'h0000, {15'h0000, cpu_reset});
    want.cpu_fail = 1'b1;
    settle();
    chk("bp cpu fail masked", 16'h0000, {15'h0000, backplane_reset});
    want.cpu_fail = 1'b0;
    $display("test reset_routing done");
    want.mains_good = 1'b1;
    want.primary_good = 1'b0;
    want.addon_present = 3'h3;
    want.addon_good = 3'h1;
    settle();
    chk("health port", 16'h00DD, {6'h00, supply_module_health});
    rd(ITEM_HEALTH, 16'h00DD, "health word");
    $display("test health done");
    // A reset in mid-run must bring both configuration words back
    wr(ITEM_RESET_CFG, 16'h003E);
    @(negedge ref_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    rd(ITEM_ALARM_CFG, 16'h0000, "alarm cfg mid reset");
    rd(ITEM_RESET_CFG, 16'h0032, "reset cfg mid reset");
    chk("alarm after reset", 16'h0000, {15'h0000, alarm_output});
    $display("test mid_reset done");
    test_done();
  end
endmodule // sscsb_top_tb
